// ===== inc/lcd_seq_pkg.sv
// Constants and types shared by the LCD segment and common sequencer
package lcd_seq_pkg;
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 8;
   localparam int          SEG_COUNT       = 40;
   localparam int          COM_COUNT       = 4;
   localparam int          NIBBLE_W        = 4;
   localparam int          SCAN_CNT_W      = 18;
   localparam int          SCAN_SHIFT_MIN  = 14;

   localparam logic [15:0] ADDR_CLK_GATE   = 16'hFF4A;
   localparam logic [15:0] ADDR_MODE       = 16'hFF90;
   localparam logic [15:0] ADDR_MEM_FIRST  = 16'hFA58;
   localparam logic [15:0] ADDR_MEM_LAST   = 16'hFA7F;

   localparam logic [7:0]  CLK_GATE_RESET  = 8'h00;
   localparam logic [7:0]  MODE_RESET      = 8'h00;
   localparam int          GATE_RUN_BIT    = 1;
   localparam int          MODE_ON_BIT     = 7;
   localparam int          MODE_CLK_LSB    = 4;
   localparam int          MODE_SEL_LSB    = 0;

   localparam logic [2:0]  MODE_4DIV_B3    = 3'h0;
   localparam logic [2:0]  MODE_3DIV_B3    = 3'h1;
   localparam logic [2:0]  MODE_3DIV_B2    = 3'h2;
   localparam logic [2:0]  MODE_2DIV_B2    = 3'h3;
   localparam logic [2:0]  MODE_STATIC     = 3'h4;
   localparam logic [2:0]  SCAN_CLK_MAXSEL = 3'h3;

   typedef enum logic {
      SCAN_STOP,
      SCAN_RUN
   } scan_state_t;

   // Number of common phases for a mode code; zero marks a prohibited code
   function automatic logic [2:0] phase_count(input logic [2:0] mode);
      unique case (mode)
         MODE_4DIV_B3: phase_count = 3'h4;
         MODE_3DIV_B3: phase_count = 3'h3;
         MODE_3DIV_B2: phase_count = 3'h3;
         MODE_2DIV_B2: phase_count = 3'h2;
         MODE_STATIC:  phase_count = 3'h1;
         default:      phase_count = 3'h0;
      endcase
   endfunction : phase_count
endpackage : lcd_seq_pkg

// ===== rtl/lcd_display_memory.sv
// Display data memory: one nibble per segment, plane read by phase
`timescale 1ns/1ps
`default_nettype none
module lcd_display_memory #(
   parameter int SEGS = lcd_seq_pkg::SEG_COUNT
) (
   input  wire logic                 mclk,     // System clock
   input  wire logic                 rst,      // Synchronous reset
   input  wire logic                 wr_en,    // Write one nibble
   input  wire logic [5:0]           wr_seg,   // Segment index written
   input  wire logic [3:0]           wr_data,  // Nibble written
   input  wire logic [5:0]           rd_seg,   // Segment index read
   output logic      [3:0]           rd_data,  // Nibble at rd_seg
   input  wire logic [1:0]           phase,    // Active common phase
   output logic      [SEGS-1:0]      plane     // Bit of each segment for phase
);
   import lcd_seq_pkg::*;

   logic [3:0] mem [SEGS];

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < SEGS; i++) begin
            mem[i] <= 4'h0;
         end
      end else if (wr_en) begin
         mem[wr_seg] <= wr_data;
      end
   end

   always_comb begin
      rd_data = mem[rd_seg];
      for (int i = 0; i < SEGS; i++) begin
         plane[i] = mem[i][phase];
      end
   end
endmodule : lcd_display_memory
`default_nettype wire

// ===== rtl/lcd_scan_divider.sv
// Scan clock divider producing one tick per LCD clock period
`timescale 1ns/1ps
`default_nettype none
module lcd_scan_divider #(
   parameter int SHIFT_MIN = lcd_seq_pkg::SCAN_SHIFT_MIN
) (
   input  wire logic       mclk,     // System clock
   input  wire logic       rst,      // Synchronous reset
   input  wire logic       run,      // Divider counts while high
   input  wire logic [2:0] clk_sel,  // Scan rate select
   output logic            tick      // One-cycle pulse per scan period
);
   import lcd_seq_pkg::*;

   typedef struct packed {
      logic [SCAN_CNT_W-1:0] count;
      logic                  tick;
   } div_state_t;

   div_state_t            st_reg;
   div_state_t            st_next;
   logic [SCAN_CNT_W-1:0] limit;

   always_comb begin
      limit   = SCAN_CNT_W'((64'(1) << (SHIFT_MIN + 3 - int'(clk_sel))) - 64'(1));
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (!run) begin
         st_next.count = '0;
      end else if (st_reg.count >= limit) begin
         st_next.count = '0;
         st_next.tick  = 1'b1;
      end else begin
         st_next.count = st_reg.count + SCAN_CNT_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;
endmodule : lcd_scan_divider
`default_nettype wire

// ===== rtl/lcd_segment_common_sequencer.sv
// Multiplexed LCD common scan and segment select sequencer
`timescale 1ns/1ps
`default_nettype none

//Operation
// - Static mode: all commons copy common zero
// - Static mode: segments use memory bit zero
// - ON only when segment and common select
// - Memory bit n drives segment in phase n
// - Two-division: scan commons 0-1, ignore rest
// - Three-division: scan commons 0-2, ignore bit3
// - Four-division: scan all four commons
// - Write-only clock gate, reset 00, stops controller
// - Gate bit 1 starts or stops LCD clock
// - Gate only acts on emulation platform
// - Display off forces segments non-select
// - Mode field selects divisions and bias
// - 40-byte memory, top address is segment zero
module lcd_segment_common_sequencer
   import lcd_seq_pkg::*;
#(
   parameter bit EMULATION_BUILD = 1'b1,
   parameter int SHIFT_MIN       = lcd_seq_pkg::SCAN_SHIFT_MIN
) (
   input  wire logic                              mclk,            // 10 MHz clock
   input  wire logic                              rst,             // Sync reset
   input  wire logic [lcd_seq_pkg::ADDR_W-1:0]    reg_addr,        // Bus address
   input  wire logic [lcd_seq_pkg::DATA_W-1:0]    reg_wdata,       // Bus write data
   input  wire logic                              reg_wr,          // Write strobe
   input  wire logic                              reg_rd,          // Read strobe
   output logic      [lcd_seq_pkg::DATA_W-1:0]    reg_rdata,       // Read data
   output logic      [lcd_seq_pkg::COM_COUNT-1:0] common_select,   // Common at select level
   output logic      [lcd_seq_pkg::COM_COUNT-1:0] common_drive_en, // Common driven, else open
   output logic      [lcd_seq_pkg::SEG_COUNT-1:0] segment_select,  // Segment at select level
   output logic                                   drive_polarity,  // Frame polarity
   output logic                                   bias_half,       // Half bias, else third
   output logic                                   lcd_scan_clock,  // Scan period pulse
   output logic                                   lcd_active       // Controller running
);
   import lcd_seq_pkg::*;

   typedef struct packed {
      scan_state_t                 state;
      logic                        lcd_clock_run;
      logic                        display_on;
      logic [2:0]                  scan_clk_sel;
      logic [2:0]                  display_mode;
      logic [1:0]                  phase;
      logic                        polarity;
      logic [DATA_W-1:0]           rdata;
      logic                        rd_mem;
      logic [COM_COUNT-1:0]        com_sel;
      logic [COM_COUNT-1:0]        com_en;
      logic [SEG_COUNT-1:0]        seg_sel;
      logic                        bias_half;
      logic                        scan_pulse;
   } seq_state_t;

   seq_state_t           st_reg;
   seq_state_t           st_next;

   logic                 clock_enabled;
   logic                 running;
   logic                 setup_ok;
   logic                 phase_ok;
   logic [2:0]           step;
   logic                 scan_tick;
   logic                 mem_hit;
   logic                 mem_wr;
   logic [5:0]           mem_seg;
   logic [3:0]           mem_rd_data;
   logic [SEG_COUNT-1:0] mem_plane;
   logic [1:0]           phase_last;

   // Segment zero sits at the highest address
   function automatic logic [5:0] seg_of(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] diff;
      diff   = ADDR_MEM_LAST - addr;
      seg_of = diff[5:0];
   endfunction : seg_of

   // Production parts ignore the gate and always supply the clock
   function automatic logic clock_supplied(input logic run_bit);
      if (EMULATION_BUILD) begin
         clock_supplied = run_bit;
      end else begin
         clock_supplied = 1'b1;
      end
   endfunction : clock_supplied

   // True when mode code and scan rate are both usable
   function automatic logic setup_legal(input logic [2:0] mode,
                                        input logic [2:0] rate);
      logic mode_ok;
      logic rate_ok;
      mode_ok     = (phase_count(mode) != 3'h0);
      rate_ok     = (rate <= SCAN_CLK_MAXSEL);
      setup_legal = mode_ok && rate_ok;
   endfunction : setup_legal

   // Highest phase index a mode scans
   function automatic logic [1:0] last_phase(input logic [2:0] mode);
      logic [2:0] count;
      count = phase_count(mode);
      if (count == 3'h0) begin
         last_phase = 2'h0;
      end else begin
         last_phase = 2'(count - 3'h1);
      end
   endfunction : last_phase

   // Next phase of the scan, with the frame wrap in the top bit
   function automatic logic [2:0] phase_step(input logic [1:0] phase,
                                             input logic [1:0] last);
      logic       wrap;
      logic [1:0] nxt_phase;
      wrap = (phase >= last);
      if (wrap) begin
         nxt_phase = 2'h0;
      end else begin
         nxt_phase = phase + 2'h1;
      end
      phase_step = {wrap, nxt_phase};
   endfunction : phase_step

   // Half bias belongs to the three- and two-phase half modes
   function automatic logic half_bias(input logic [2:0] mode);
      unique case (mode)
         MODE_3DIV_B2: half_bias = 1'b1;
         MODE_2DIV_B2: half_bias = 1'b1;
         default:      half_bias = 1'b0;
      endcase
   endfunction : half_bias

   // Commons driven in a mode; the rest stay open
   function automatic logic [COM_COUNT-1:0] com_enable_mask(input logic [2:0] mode);
      unique case (mode)
         MODE_4DIV_B3: com_enable_mask = 4'hF;
         MODE_3DIV_B3: com_enable_mask = 4'h7;
         MODE_3DIV_B2: com_enable_mask = 4'h7;
         MODE_2DIV_B2: com_enable_mask = 4'h3;
         MODE_STATIC:  com_enable_mask = 4'hF;
         default:      com_enable_mask = 4'h0;
      endcase
   endfunction : com_enable_mask

   // Commons at select level; an open common is never selected
   function automatic logic [COM_COUNT-1:0] com_select_mask(input logic [2:0] mode,
                                                             input logic [1:0] phase);
      logic [COM_COUNT-1:0] one_hot;
      one_hot        = '0;
      one_hot[phase] = 1'b1;
      if (mode == MODE_STATIC) begin
         com_select_mask = '1;
      end else begin
         com_select_mask = one_hot & com_enable_mask(mode);
      end
   endfunction : com_select_mask

   // Segment levels: memory plane of the phase, or all non-select
   function automatic logic [SEG_COUNT-1:0] segment_levels(
      input logic [SEG_COUNT-1:0] plane,
      input logic                 run,
      input logic                 on,
      input logic                 in_range
   );
      if (run && on && in_range) begin
         // Static holds phase zero, so bit zero is used
         segment_levels = plane;
      end else begin
         segment_levels = '0;
      end
   endfunction : segment_levels

   // Read view of the mode register; bit 3 reads as zero
   function automatic logic [DATA_W-1:0] mode_view(input logic       on,
                                                   input logic [2:0] rate,
                                                   input logic [2:0] mode);
      mode_view                    = '0;
      mode_view[MODE_ON_BIT]       = on;
      mode_view[MODE_CLK_LSB +: 3] = rate;
      mode_view[MODE_SEL_LSB +: 3] = mode;
   endfunction : mode_view

   // Read data of one access; unmapped and write-only addresses read zero
   function automatic logic [DATA_W-1:0] read_view(input logic [ADDR_W-1:0] addr,
                                                   input logic              hit,
                                                   input logic [3:0]        nibble,
                                                   input logic [DATA_W-1:0] mode_byte);
      if (addr == ADDR_MODE) begin
         read_view = mode_byte;
      end else if (hit) begin
         read_view = {4'h0, nibble};
      end else begin
         // Clock gate is write-only and reads as zero
         read_view = '0;
      end
   endfunction : read_view

   // Register write; only the run bit of the gate is kept
   function automatic seq_state_t apply_write(input seq_state_t          s,
                                              input logic [ADDR_W-1:0] addr,
                                              input logic [DATA_W-1:0] data);
      apply_write = s;
      if (addr == ADDR_CLK_GATE) begin
         apply_write.lcd_clock_run = data[GATE_RUN_BIT];
      end else if (addr == ADDR_MODE) begin
         apply_write.display_on   = data[MODE_ON_BIT];
         apply_write.scan_clk_sel = data[MODE_CLK_LSB +: 3];
         apply_write.display_mode = data[MODE_SEL_LSB +: 3];
      end
   endfunction : apply_write

   // Register contents right after reset
   function automatic seq_state_t reset_state();
      seq_state_t s;
      s               = '0;
      s.state         = SCAN_STOP;
      s.lcd_clock_run = CLK_GATE_RESET[GATE_RUN_BIT];
      s.display_on    = MODE_RESET[MODE_ON_BIT];
      s.scan_clk_sel  = MODE_RESET[MODE_CLK_LSB +: 3];
      s.display_mode  = MODE_RESET[MODE_SEL_LSB +: 3];
      reset_state     = s;
   endfunction : reset_state

   assign mem_hit = (reg_addr >= ADDR_MEM_FIRST) && (reg_addr <= ADDR_MEM_LAST);
   assign mem_wr  = reg_wr && mem_hit;
   assign mem_seg = seg_of(reg_addr);

   assign clock_enabled = clock_supplied(st_reg.lcd_clock_run);
   assign running       = (st_reg.state == SCAN_RUN);

   // Phase bookkeeping for the selected mode
   assign setup_ok   = setup_legal(st_reg.display_mode, st_reg.scan_clk_sel);
   assign phase_last = last_phase(st_reg.display_mode);
   assign phase_ok   = (st_reg.phase <= phase_last);
   assign step       = phase_step(st_reg.phase, phase_last);

   lcd_scan_divider #(
      .SHIFT_MIN (SHIFT_MIN)
   ) u_div (
      .mclk    (mclk),
      .rst     (rst),
      .run     (running),
      .clk_sel (st_reg.scan_clk_sel),
      .tick    (scan_tick)
   );

   lcd_display_memory #(
      .SEGS (SEG_COUNT)
   ) u_mem (
      .mclk    (mclk),
      .rst     (rst),
      .wr_en   (mem_wr),
      .wr_seg  (mem_seg),
      .wr_data (reg_wdata[3:0]),
      .rd_seg  (mem_seg),
      .rd_data (mem_rd_data),
      .phase   (st_reg.phase),
      .plane   (mem_plane)
   );

   always_comb begin
      st_next            = st_reg;
      st_next.rd_mem     = 1'b0;
      st_next.scan_pulse = scan_tick;

      // Register writes
      if (reg_wr) begin
         st_next = apply_write(st_next, reg_addr, reg_wdata);
      end

      // Register reads; data stand in the following cycle
      st_next.rdata = '0;
      if (reg_rd) begin
         st_next.rdata = read_view(reg_addr, mem_hit, mem_rd_data,
                                   mode_view(st_reg.display_on, st_reg.scan_clk_sel,
                                             st_reg.display_mode));
      end

      // Scan state: runs only with clock supplied and a legal setup
      unique case (st_reg.state)
         SCAN_STOP: begin
            st_next.phase    = 2'h0;
            st_next.polarity = 1'b0;
            if (clock_enabled && setup_ok) begin
               st_next.state = SCAN_RUN;
            end
         end
         SCAN_RUN: begin
            if (!clock_enabled || !setup_ok) begin
               st_next.state = SCAN_STOP;
            end else if (!phase_ok) begin
               // A shorter mode left the phase out of range: restart the frame
               st_next.phase = 2'h0;
            end else if (scan_tick) begin
               // Scan only the phases the mode uses
               st_next.phase = step[1:0];
               if (step[2]) begin
                  st_next.polarity = !st_reg.polarity;
               end
            end
         end
      endcase

      // Common outputs
      st_next.bias_half = half_bias(st_reg.display_mode);
      if (running) begin
         st_next.com_en  = com_enable_mask(st_reg.display_mode);
         st_next.com_sel = com_select_mask(st_reg.display_mode, st_reg.phase);
      end else begin
         st_next.com_en  = '0;
         st_next.com_sel = '0;
      end

      // Segment outputs; bits of phases outside the mode are never shown
      st_next.seg_sel = segment_levels(mem_plane, running, st_reg.display_on,
                                       phase_ok);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= reset_state();
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata       = st_reg.rdata;
   assign common_select   = st_reg.com_sel;
   assign common_drive_en = st_reg.com_en;
   assign segment_select  = st_reg.seg_sel;
   assign drive_polarity  = st_reg.polarity;
   assign bias_half       = st_reg.bias_half;
   assign lcd_scan_clock  = st_reg.scan_pulse;
   assign lcd_active      = running;
endmodule : lcd_segment_common_sequencer
`default_nettype wire

// ===== tb/lcd_panel_model.sv
// Passive glass model: pixels at full ON level this phase
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
   input  wire logic [3:0]  common_select,   // Commons
   input  wire logic [3:0]  common_drive_en, // Enables
   input  wire logic [39:0] segment_select,  // Segments
   output logic      [39:0] lit              // Lit pixels
);
   // An open common never lights a pixel
   assign lit = segment_select & {40{|(common_select & common_drive_en)}};
endmodule : lcd_panel_model
`default_nettype wire

// ===== tb/lcd_segment_common_sequencer_tb.sv
// Self-checking bench for the LCD sequencer
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_common_sequencer_tb;
   import lcd_seq_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic [3:0]  common_select, common_drive_en;
   logic [39:0] segment_select, lit;
   logic        drive_polarity, bias_half, lcd_scan_clock, lcd_active, prod_active;
   logic [3:0]  mem [40];
   logic [7:0]  bad [3] = '{8'hB5, 8'hB7, 8'hC0};
   int          fail_count = 0;
   int          n_checks = 0;
   int          k;
   always #50 mclk = ~mclk;
   lcd_segment_common_sequencer #(.EMULATION_BUILD(1'b1), .SHIFT_MIN(2)) DUT (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .common_select(common_select),
      .common_drive_en(common_drive_en), .segment_select(segment_select),
      .drive_polarity(drive_polarity), .bias_half(bias_half),
      .lcd_scan_clock(lcd_scan_clock), .lcd_active(lcd_active));
   lcd_segment_common_sequencer #(.EMULATION_BUILD(1'b0), .SHIFT_MIN(2)) DUT_PROD (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(), .common_select(), .common_drive_en(),
      .segment_select(), .drive_polarity(), .bias_half(), .lcd_scan_clock(),
      .lcd_active(prod_active));
   lcd_panel_model PANEL (.common_select(common_select), .common_drive_en(common_drive_en),
      .segment_select(segment_select), .lit(lit));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input string what);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(what, {32'h0, e}, {32'h0, reg_rdata});
   endtask : rd
   task automatic settle;
      repeat (3) @(posedge mclk);
      #1;
   endtask : settle
   // Segment levels expected for a phase
   function automatic logic [39:0] plane(input int ph);
      logic [39:0] p;
      for (int i = 0; i < 40; i++) p[i] = mem[i][ph];
      return p;
   endfunction : plane
   task automatic wait_until(input logic [3:0] e, input logic pol, input bit on_pol);
      int i;
      for (i = 0; i < 200 && (on_pol ? drive_polarity === pol : common_select !== e); i++) begin
         @(posedge mclk);
         #1;
      end
      if (i == 200) begin
         fail_count++;
         $display("[ERR] wait expected %h seen %h", e, common_select);
         complete_run();
      end
   endtask : wait_until
   task automatic scan(input logic [2:0] code, input int np, input logic [3:0] en, input logic hb);
      logic pol0;
      time  t0;
      wr(ADDR_MODE, {5'b10110, code});
      settle();
      pol0 = drive_polarity;
      wait_until(4'h0, pol0, 1'b1);
      t0   = $time;
      pol0 = drive_polarity;
      for (int n = 0; n < np; n++) begin
         wait_until(np == 1 ? 4'hF : 4'h1 << n, 1'b0, 1'b0);
         chk("common enables", en, common_drive_en);
         chk("segments", plane(np == 1 ? 0 : n), segment_select);
         chk("lit pixels", plane(np == 1 ? 0 : n), lit);
         chk("bias", hb, bias_half);
      end
      wait_until(4'h0, pol0, 1'b1);
      chk("frame cycles", 40'(np * 4), 40'(($time - t0) / 100));
   endtask : scan
   initial begin
      void'($urandom(18));
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk("active after reset", 0, lcd_active);
      rd(ADDR_CLK_GATE, CLK_GATE_RESET, "gate read");
      rd(ADDR_MODE, MODE_RESET, "mode reset");
      for (k = 0; k < 40; k++) begin
         mem[k] = (k == 28) ? 4'hD : 4'($urandom);
         wr(ADDR_MEM_LAST - 16'(k), {4'($urandom), mem[k]});
      end
      rd(ADDR_MEM_LAST, {4'h0, mem[0]}, "segment zero byte");
      rd(ADDR_MEM_FIRST, {4'h0, mem[39]}, "segment 39 byte");
      rd(16'h1234, 8'h00, "unmapped read");
      wr(ADDR_MODE, 8'hB0);
      settle();
      chk("run without gate", 0, lcd_active);
      chk("production run", 1, prod_active);
      wr(ADDR_CLK_GATE, 8'h02);
      scan(MODE_4DIV_B3, 4, 4'hF, 1'b0);
      scan(MODE_3DIV_B3, 3, 4'h7, 1'b0);
      scan(MODE_3DIV_B2, 3, 4'h7, 1'b1);
      scan(MODE_2DIV_B2, 2, 4'h3, 1'b1);
      scan(MODE_STATIC, 1, 4'hF, 1'b0);
      wr(ADDR_MODE, 8'h30);
      settle();
      chk("display off", 0, segment_select);
      foreach (bad[i]) begin
         wr(ADDR_MODE, bad[i]);
         settle();
         chk("prohibited setting", 0, lcd_active);
      end
      wr(ADDR_MODE, 8'hB0);
      wr(ADDR_CLK_GATE, 8'h00);
      settle();
      chk("gate stop", 0, lcd_active);
      chk("production ignores gate", 1, prod_active);
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk("active after mid reset", 0, lcd_active);
      rd(ADDR_MEM_LAST, 8'h00, "memory after reset");
      complete_run();
   end
endmodule : lcd_segment_common_sequencer_tb
`default_nettype wire

// ===== tb/lcd_seq_properties.sv
// Port-level checker for the LCD sequencer
`timescale 1ns/1ps
`default_nettype none
module lcd_seq_properties
   import lcd_seq_pkg::*;
#(
   parameter bit EMULATION_BUILD = 1'b1,
   parameter int SHIFT_MIN       = SCAN_SHIFT_MIN
) (
   input wire logic        mclk,            // Clock
   input wire logic        rst,             // Reset
   input wire logic [15:0] reg_addr,        // Address
   input wire logic [7:0]  reg_wdata,       // Write data
   input wire logic        reg_wr,          // Write
   input wire logic        reg_rd,          // Read
   input wire logic [7:0]  reg_rdata,       // Read data
   input wire logic [3:0]  common_select,   // Commons
   input wire logic [3:0]  common_drive_en, // Enables
   input wire logic [39:0] segment_select,  // Segments
   input wire logic        drive_polarity,  // Polarity
   input wire logic        bias_half,       // Bias
   input wire logic        lcd_scan_clock,  // Scan pulse
   input wire logic        lcd_active       // Running
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence mode_wr_s; reg_wr && reg_addr == ADDR_MODE; endsequence
   sequence quiet_s; !reg_wr [*3]; endsequence
   AST_STOP_QUIET: assert property (
      !lcd_active && !$past(lcd_active) |-> common_drive_en == 4'h0 && segment_select == '0)
      else $error("outputs driven while stopped");
   AST_SEL_DRIVEN: assert property ((common_select & ~common_drive_en) == 4'h0)
      else $error("open common selected");
   AST_EN_SHAPE: assert property (common_drive_en inside {4'h0, 4'h3, 4'h7, 4'hF})
      else $error("bad common enable set");
   AST_STATIC_ALL: assert property (common_select == 4'hF |-> common_drive_en == 4'hF)
      else $error("static commons not all driven");
   AST_SCAN_PULSE: assert property (lcd_scan_clock |=> !lcd_scan_clock [*3])
      else $error("scan pulse too close");
   AST_PHASE_TICK: assert property (
      $changed(common_select) && $past(lcd_active, 2) && $past(lcd_active) && lcd_active
      && !$past(reg_wr)
      && !$past(reg_wr, 2) && !$past(reg_wr, 3) |-> $past(lcd_scan_clock)
      || $past(lcd_scan_clock, 2)) else $error("phase moved without scan pulse");
   AST_WO_READ: assert property (reg_rd && reg_addr == ADDR_CLK_GATE |=> reg_rdata == 8'h00)
      else $error("gate register readable");
   AST_MEM_UPPER: assert property (
      reg_rd && reg_addr inside {[ADDR_MEM_FIRST:ADDR_MEM_LAST]} |=> reg_rdata[7:4] == 4'h0)
      else $error("memory upper bits not zero");
   AST_OFF_BLANK: assert property (
      mode_wr_s ##0 !reg_wdata[MODE_ON_BIT] ##1 quiet_s |-> segment_select == '0)
      else $error("segments selected with display off");
   AST_HALF_BIAS: assert property (
      mode_wr_s ##0 reg_wdata[2:0] inside {3'h2, 3'h3} ##1 quiet_s |-> bias_half)
      else $error("half bias flag missing");
   AST_BAD_STOP: assert property (
      mode_wr_s ##0 reg_wdata[2:0] > 3'h4 ##1 quiet_s |-> !lcd_active)
      else $error("prohibited mode keeps running");
endmodule : lcd_seq_properties
bind lcd_segment_common_sequencer lcd_seq_properties #(
   .EMULATION_BUILD(EMULATION_BUILD), .SHIFT_MIN(SHIFT_MIN)
) u_props (
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .common_select(common_select),
   .common_drive_en(common_drive_en), .segment_select(segment_select),
   .drive_polarity(drive_polarity), .bias_half(bias_half),
   .lcd_scan_clock(lcd_scan_clock), .lcd_active(lcd_active)
);
`default_nettype wire
